// [design/llrm_pkg.sv]
// Purpose: Shared constants and types for the link local request machine
// Assumes: One system clock, synchronous reset
// Notes:   Frame type and control codes are local encodings
package llrm_pkg;

  // Frame type codes
  localparam logic [2:0] LLRM_NOACK_DATA_FRAME_TYPE    = 3'h0;
  localparam logic [2:0] LLRM_ACK_DATA_FRAME_TYPE      = 3'h1;
  localparam logic [2:0] LLRM_REQUEST_DATA_FRAME_TYPE  = 3'h2;
  localparam logic [2:0] LLRM_ACK_RESPONSE_FRAME_TYPE  = 3'h3;
  localparam logic [2:0] LLRM_DATA_RESPONSE_FRAME_TYPE = 3'h4;

  // Medium control codes
  localparam logic [1:0] LLRM_REQUEST_NO_REPLY_CTL      = 2'h0;
  localparam logic [1:0] LLRM_REQUEST_WITH_RESPONSE_CTL = 2'h1;

  // User request kinds
  localparam logic [1:0] LLRM_REQ_ACK_SEND   = 2'h0;
  localparam logic [1:0] LLRM_REQ_NOACK_SEND = 2'h1;
  localparam logic [1:0] LLRM_REQ_REPLY      = 2'h2;

  // Status codes
  localparam logic [1:0] LLRM_STATUS_OK = 2'h0;

  // Fixed sequence bit of unacknowledged frames
  localparam logic       LLRM_NOACK_SEQ = 1'b0;

  // Widths and reset value
  localparam int         LLRM_ADDR_W  = 4;
  localparam int         LLRM_SAP_W   = 8;
  localparam int         LLRM_PRIO_W  = 2;
  localparam int         LLRM_DATA_W  = 32;
  localparam logic       LLRM_SEQ_RST = 1'b0;

  typedef enum logic [2:0] {
    LLRM_CONFIGURE           = 3'b000,
    LLRM_IDLE                = 3'b001,
    LLRM_ACK_SEND_STATE      = 3'b010,
    LLRM_ACK_WAIT_STATE      = 3'b011,
    LLRM_NOACK_SEND_STATE    = 3'b100,
    LLRM_NOACK_SENT_STATE    = 3'b101,
    LLRM_REPLY_REQUEST_STATE = 3'b110,
    LLRM_REPLY_WAIT_STATE    = 3'b111
  } llrm_state_t;

endpackage : llrm_pkg

// [design/llrm_seq_table.sv]
// Purpose: Per-remote sequence bit store with toggle
// Assumes: Toggle and read on the same clock
// Notes:   All bits start at the reset value
`timescale 1ns/1ps
`default_nettype none
module llrm_seq_table #(
  parameter int ADDR_W = llrm_pkg::LLRM_ADDR_W
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic                   rd_seq_o,
  // Toggle port
  input  wire logic              toggle_i,
  input  wire logic [ADDR_W-1:0] toggle_addr_i
);

  typedef struct packed {
    logic [(1<<ADDR_W)-1:0] seq;
  } llrm_seq_st_t;

  llrm_seq_st_t st_q;
  llrm_seq_st_t st_d;

  // Next sequence bits
  always_comb begin
    st_d = st_q;
    if (toggle_i) begin
      st_d.seq[toggle_addr_i] = ~st_q.seq[toggle_addr_i];
    end
  end

  // Register the table
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q.seq <= {(1<<ADDR_W){llrm_pkg::LLRM_SEQ_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_seq_o = st_q.seq[rd_addr_i];

endmodule : llrm_seq_table
`default_nettype wire

// [design/llrm_local.sv]
// Purpose: Local request machine for one access point and priority
// Assumes: User and medium side are logic on sys_clk_i
// Notes:   One instance per access point and priority pairing
// How it works
// - Serves ack, no-ack and reply requests only
// - No-ack frame: seq 0, data, no-reply control
// - Ack wait ends on matching response and ok
// - Reply frame: remote seq, empty, with-response control
// - One instance per access point and priority
// - Unlisted events change nothing, do nothing
// - Transition actions in listed order only
`timescale 1ns/1ps
`default_nettype none
module llrm_local #(
  parameter int                               ADDR_W = llrm_pkg::LLRM_ADDR_W,
  parameter int                               SAP_W  = llrm_pkg::LLRM_SAP_W,
  parameter int                               PRIO_W = llrm_pkg::LLRM_PRIO_W,
  parameter int                               DATA_W = llrm_pkg::LLRM_DATA_W,
  parameter logic [SAP_W-1:0]                 OWN_SAP  = 8'h00,
  parameter logic [PRIO_W-1:0]                OWN_PRIO = 2'h0
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // Activation
  input  wire logic              local_active_i,
  // User request
  input  wire logic              req_valid_i,
  input  wire logic [1:0]        req_kind_i,
  input  wire logic [SAP_W-1:0]  req_dsap_i,
  input  wire logic [ADDR_W-1:0] req_ra_i,
  input  wire logic [DATA_W-1:0] req_data_i,
  output logic                   req_ready_o,
  // Validation result for the held request
  input  wire logic              valid_ok_i,
  input  wire logic              valid_fail_i,
  input  wire logic [1:0]        valid_status_i,
  // User confirmation
  output logic                   cnf_valid_o,
  output logic [1:0]             cnf_kind_o,
  output logic [1:0]             cnf_status_o,
  output logic [SAP_W-1:0]       cnf_ssap_o,
  output logic [SAP_W-1:0]       cnf_dsap_o,
  output logic [ADDR_W-1:0]      cnf_ra_o,
  output logic [PRIO_W-1:0]      cnf_prio_o,
  output logic [DATA_W-1:0]      cnf_data_o,
  output logic                   cnf_has_data_o,
  // Medium request
  output logic                   ma_req_o,
  output logic [ADDR_W-1:0]      ma_da_o,
  output logic [2:0]             ma_type_o,
  output logic                   ma_seq_o,
  output logic [SAP_W-1:0]       ma_ssap_o,
  output logic [SAP_W-1:0]       ma_dsap_o,
  output logic [DATA_W-1:0]      ma_data_o,
  output logic                   ma_has_data_o,
  output logic [1:0]             ma_ctl_o,
  output logic [PRIO_W-1:0]      ma_prio_o,
  // Medium confirmation and indication
  input  wire logic              ma_cnf_i,
  input  wire logic [1:0]        ma_cnf_status_i,
  input  wire logic              ma_ind_i,
  input  wire logic [ADDR_W-1:0] ma_ind_sa_i,
  input  wire logic [SAP_W-1:0]  ma_ind_ssap_i,
  input  wire logic [2:0]        ma_ind_type_i,
  input  wire logic [DATA_W-1:0] ma_ind_data_i,
  input  wire logic              ma_ind_has_data_i,
  // Management
  output logic                   management_alert_o
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    llrm_pkg::llrm_state_t state;
    logic [1:0]            kind;
    logic [SAP_W-1:0]      dsap;
    logic [ADDR_W-1:0]     ra;
    logic [DATA_W-1:0]     data;
    logic                  cnf_valid;
    logic [1:0]            cnf_status;
    logic [DATA_W-1:0]     cnf_data;
    logic                  cnf_has_data;
    logic                  ma_req;
    logic [2:0]            ma_type;
    logic                  ma_seq;
    logic [DATA_W-1:0]     ma_data;
    logic                  ma_has_data;
    logic [1:0]            ma_ctl;
    logic                  alert;
    logic                  seq_toggle;
  } llrm_st_t;

  llrm_st_t st_q;
  llrm_st_t st_d;
  logic     cur_seq;

  // Response matches current remote, access point and type
  function automatic logic llrm_match(input logic [2:0] t);
    llrm_match = (ma_ind_sa_i == st_q.ra) && (ma_ind_ssap_i == st_q.dsap) && (ma_ind_type_i == t);
  endfunction : llrm_match

  ////////////////////////////////////////////////////////////////////////
  // Sequence bits per remote

  llrm_seq_table #(
    .ADDR_W (ADDR_W)
  ) u_seq (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .rd_addr_i     (st_q.ra),
    .rd_seq_o      (cur_seq),
    .toggle_i      (st_q.seq_toggle),
    .toggle_addr_i (st_q.ra)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state and actions

  always_comb begin
    st_d            = st_q;
    st_d.cnf_valid  = 1'b0;
    st_d.ma_req     = 1'b0;
    st_d.alert      = 1'b0;
    st_d.seq_toggle = 1'b0;
    unique case (st_q.state)
      llrm_pkg::LLRM_CONFIGURE: begin
        if (local_active_i) st_d.state = llrm_pkg::LLRM_IDLE;
      end
      llrm_pkg::LLRM_IDLE: begin
        if (!local_active_i) begin
          st_d.state = llrm_pkg::LLRM_CONFIGURE;
        end else if (req_valid_i && req_kind_i != 2'h3) begin
          st_d.kind = req_kind_i; // Save request context
          st_d.dsap = req_dsap_i;
          st_d.ra   = req_ra_i;
          st_d.data = req_data_i;
          unique case (req_kind_i)
            llrm_pkg::LLRM_REQ_ACK_SEND:   st_d.state = llrm_pkg::LLRM_ACK_SEND_STATE;
            llrm_pkg::LLRM_REQ_NOACK_SEND: st_d.state = llrm_pkg::LLRM_NOACK_SEND_STATE;
            default:                       st_d.state = llrm_pkg::LLRM_REPLY_REQUEST_STATE;
          endcase
        end
      end
      llrm_pkg::LLRM_ACK_SEND_STATE,
      llrm_pkg::LLRM_NOACK_SEND_STATE,
      llrm_pkg::LLRM_REPLY_REQUEST_STATE: begin
        st_d.ma_data     = st_q.data;
        st_d.ma_has_data = 1'b1;
        st_d.ma_ctl      = llrm_pkg::LLRM_REQUEST_WITH_RESPONSE_CTL;
        st_d.ma_seq      = cur_seq;
        if (st_q.state == llrm_pkg::LLRM_ACK_SEND_STATE) begin
          st_d.ma_type = llrm_pkg::LLRM_ACK_DATA_FRAME_TYPE;
        end else if (st_q.state == llrm_pkg::LLRM_NOACK_SEND_STATE) begin
          st_d.ma_type = llrm_pkg::LLRM_NOACK_DATA_FRAME_TYPE;
          st_d.ma_seq  = llrm_pkg::LLRM_NOACK_SEQ;
          st_d.ma_ctl  = llrm_pkg::LLRM_REQUEST_NO_REPLY_CTL;
        end else begin
          st_d.ma_type     = llrm_pkg::LLRM_REQUEST_DATA_FRAME_TYPE;
          st_d.ma_data     = '0;
          st_d.ma_has_data = 1'b0;
        end
        if (valid_ok_i) begin
          st_d.ma_req = 1'b1;
          st_d.state  = llrm_state_next(st_q.state);
        end else if (valid_fail_i) begin
          st_d.cnf_valid    = 1'b1;
          st_d.cnf_status   = valid_status_i;
          st_d.cnf_has_data = 1'b0;
          st_d.cnf_data     = '0;
          st_d.state        = llrm_pkg::LLRM_IDLE;
        end
      end
      llrm_pkg::LLRM_NOACK_SENT_STATE: begin
        if (ma_cnf_i) begin
          st_d.cnf_valid    = 1'b1;
          st_d.cnf_status   = ma_cnf_status_i;
          st_d.cnf_has_data = 1'b0;
          st_d.cnf_data     = '0;
          st_d.state        = llrm_pkg::LLRM_IDLE;
        end
      end
      llrm_pkg::LLRM_ACK_WAIT_STATE,
      llrm_pkg::LLRM_REPLY_WAIT_STATE: begin
        if (ma_cnf_i && ma_cnf_status_i != llrm_pkg::LLRM_STATUS_OK) begin
          st_d.cnf_valid    = 1'b1;
          st_d.cnf_status   = ma_cnf_status_i;
          st_d.cnf_has_data = 1'b0;
          st_d.cnf_data     = '0;
          st_d.state        = llrm_pkg::LLRM_IDLE;
        end else if (ma_ind_i && ma_cnf_i && llrm_match(st_q.state == llrm_pkg::LLRM_ACK_WAIT_STATE ?
                     llrm_pkg::LLRM_ACK_RESPONSE_FRAME_TYPE : llrm_pkg::LLRM_DATA_RESPONSE_FRAME_TYPE)
                     && !(st_q.state == llrm_pkg::LLRM_ACK_WAIT_STATE && ma_ind_has_data_i)) begin
          st_d.cnf_valid    = 1'b1;
          st_d.cnf_status   = llrm_pkg::LLRM_STATUS_OK;
          st_d.cnf_has_data = (st_q.state == llrm_pkg::LLRM_REPLY_WAIT_STATE) && ma_ind_has_data_i;
          st_d.cnf_data     = (st_q.state == llrm_pkg::LLRM_REPLY_WAIT_STATE) ? ma_ind_data_i : '0;
          st_d.seq_toggle   = 1'b1;
          st_d.state        = llrm_pkg::LLRM_IDLE;
        end else if (ma_ind_i) begin
          st_d.alert = 1'b1;
          st_d.state = llrm_pkg::LLRM_IDLE;
        end
      end
      default: st_d = st_q;
    endcase
  end

  // Successor state after a frame is sent
  function automatic llrm_pkg::llrm_state_t llrm_state_next(input llrm_pkg::llrm_state_t s);
    unique case (s)
      llrm_pkg::LLRM_ACK_SEND_STATE:   llrm_state_next = llrm_pkg::LLRM_ACK_WAIT_STATE;
      llrm_pkg::LLRM_NOACK_SEND_STATE: llrm_state_next = llrm_pkg::LLRM_NOACK_SENT_STATE;
      default:                         llrm_state_next = llrm_pkg::LLRM_REPLY_WAIT_STATE;
    endcase
  endfunction : llrm_state_next

  // Register all state
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q       <= '0;
      st_q.state <= llrm_pkg::LLRM_CONFIGURE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign req_ready_o        = (st_q.state == llrm_pkg::LLRM_IDLE) && local_active_i;
  assign cnf_valid_o        = st_q.cnf_valid;
  assign cnf_kind_o         = st_q.kind;
  assign cnf_status_o       = st_q.cnf_status;
  assign cnf_ssap_o         = OWN_SAP;
  assign cnf_dsap_o         = st_q.dsap;
  assign cnf_ra_o           = st_q.ra;
  assign cnf_prio_o         = OWN_PRIO;
  assign cnf_data_o         = st_q.cnf_data;
  assign cnf_has_data_o     = st_q.cnf_has_data;
  assign ma_req_o           = st_q.ma_req;
  assign ma_da_o            = st_q.ra;
  assign ma_type_o          = st_q.ma_type;
  assign ma_seq_o           = st_q.ma_seq;
  assign ma_ssap_o          = OWN_SAP;
  assign ma_dsap_o          = st_q.dsap;
  assign ma_data_o          = st_q.ma_data;
  assign ma_has_data_o      = st_q.ma_has_data;
  assign ma_ctl_o           = st_q.ma_ctl;
  assign ma_prio_o          = OWN_PRIO;
  assign management_alert_o = st_q.alert;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_noack_go;
    st_q.state == llrm_pkg::LLRM_NOACK_SEND_STATE && valid_ok_i;
  endsequence

  a_noack_frame: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_noack_go |=> ma_req_o && !ma_seq_o && ma_ctl_o == llrm_pkg::LLRM_REQUEST_NO_REPLY_CTL)
    else $error("no-ack frame fields wrong");

  a_reply_frame: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_q.state == llrm_pkg::LLRM_REPLY_REQUEST_STATE && valid_ok_i |=> ma_req_o && !ma_has_data_o
    && ma_type_o == llrm_pkg::LLRM_REQUEST_DATA_FRAME_TYPE && ma_ctl_o == llrm_pkg::LLRM_REQUEST_WITH_RESPONSE_CTL
    && st_q.state == llrm_pkg::LLRM_REPLY_WAIT_STATE)
    else $error("reply frame fields wrong");

  a_ack_done: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_q.seq_toggle |-> $past(st_q.state) inside {llrm_pkg::LLRM_ACK_WAIT_STATE, llrm_pkg::LLRM_REPLY_WAIT_STATE}
    && cnf_valid_o && cnf_status_o == llrm_pkg::LLRM_STATUS_OK ##1 cur_seq != $past(cur_seq))
    else $error("sequence not toggled on completion");

  a_idle_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_q.state == llrm_pkg::LLRM_IDLE && local_active_i && !req_valid_i |=> st_q.state == llrm_pkg::LLRM_IDLE
    && !ma_req_o && !cnf_valid_o)
    else $error("idle left without request");

  a_fail_cnf: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_q.state == llrm_pkg::LLRM_ACK_WAIT_STATE && ma_cnf_i && ma_cnf_status_i != llrm_pkg::LLRM_STATUS_OK
    |=> cnf_valid_o && cnf_status_o == $past(ma_cnf_status_i) && st_q.state == llrm_pkg::LLRM_IDLE)
    else $error("failed medium confirm not reported");

  a_one_action: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(ma_req_o && (cnf_valid_o || management_alert_o)))
    else $error("extra action on transition");

  a_bad_req: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_q.state == llrm_pkg::LLRM_IDLE && req_valid_i && req_kind_i == 2'h3 |=> st_q.state == llrm_pkg::LLRM_IDLE)
    else $error("unsupported request accepted");

  a_fixed_prio: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ma_req_o |-> ma_prio_o == OWN_PRIO && ma_ssap_o == OWN_SAP)
    else $error("wrong invocation priority");

endmodule : llrm_local
`default_nettype wire

// [verif/llrm_ma_model.sv]
// Purpose: Medium access partner for the local request machine
// Assumes: Mode, delay and reply data held by the bench for one frame
// Notes:   Mode 0 ok, 1 bad status, 2 stray frame without confirm (no-reply frames still get an ok confirm)
`timescale 1ns/1ps
`default_nettype none
module llrm_ma_model (
  // Clock and control
  input  wire logic        sys_clk_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic [31:0] rsp_data_i,
  // Frame from the machine
  input  wire logic        ma_req_i,
  input  wire logic [3:0]  ma_da_i,
  input  wire logic [2:0]  ma_type_i,
  input  wire logic [7:0]  ma_dsap_i,
  input  wire logic [1:0]  ma_ctl_i,
  // Answers to the machine
  output logic             cnf_o,
  output logic [1:0]       cnf_status_o,
  output logic             ind_o,
  output logic [3:0]       sa_o,
  output logic [7:0]       ssap_o,
  output logic [2:0]       type_o,
  output logic [31:0]      data_o,
  output logic             has_data_o
);
  logic       busy_q = 1'b0;
  logic [3:0] cnt_q  = 4'h0;
  logic [3:0] junk_q = 4'h0;
  logic [3:0] da_q;
  logic [7:0] dsap_q;
  logic [2:0] typ_q;
  logic [1:0] ctl_q;
  initial cnf_o = 1'b0;
  initial ind_o = 1'b0;
  //////////////////////////////////////////////////////////////////
  // Latch frame, count down, answer once
  always @(posedge sys_clk_i) begin
    cnf_o <= 1'b0;
    ind_o <= 1'b0;
    junk_q <= junk_q + 4'h1;
    if (ma_req_i) begin
      busy_q <= 1'b1;
      cnt_q <= dly_i;
      da_q <= ma_da_i;
      dsap_q <= ma_dsap_i;
      typ_q <= ma_type_i;
      ctl_q <= ma_ctl_i;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      cnf_o <= mode_i != 2'h2 || ctl_q == 2'h0;
      cnf_status_o <= (mode_i == 2'h1) ? 2'h2 : 2'h0;
      ind_o <= ctl_q == 2'h1 && mode_i != 2'h1;
    end
  end
  // Response fields; idle lines toss instead of holding
  assign sa_o       = ind_o ? ((mode_i == 2'h2) ? ~da_q : da_q) : junk_q;
  assign ssap_o     = ind_o ? dsap_q : {2{junk_q}};
  assign type_o     = ind_o ? ((typ_q == 3'h1) ? 3'h3 : 3'h4) : junk_q[2:0];
  assign data_o     = ind_o ? rsp_data_i : {8{junk_q}};
  assign has_data_o = ind_o ? typ_q == 3'h2 : junk_q[0];
endmodule : llrm_ma_model
`default_nettype wire

// [verif/test_link_local_request_machine.sv]
// Purpose: Self-checking bench for the local request machine
// Assumes: Validator pulses and user requests come from the bench
// Notes:   Random ops from a fixed xorshift seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
module test_link_local_request_machine;
  logic sys_clk_i = 0, srst_i = 1, local_active_i = 0, req_valid_i = 0;
  logic [1:0] req_kind_i = 0, valid_status_i = 0, ma_cnf_status_i, cnf_kind_o, cnf_status_o, ma_ctl_o, mode = 0;
  logic [7:0] req_dsap_i = 0, ma_ind_ssap_i, cnf_ssap_o, cnf_dsap_o, ma_ssap_o, ma_dsap_o, e_ds;
  logic [3:0] req_ra_i = 0, ma_ind_sa_i, cnf_ra_o, ma_da_o, dly = 0, e_ra;
  logic [31:0] req_data_i = 0, ma_ind_data_i, cnf_data_o, ma_data_o, rsp = 0, e_dt, rs = 32'h8B8566D5;
  logic valid_ok_i = 0, valid_fail_i = 0, ma_cnf_i, ma_ind_i, ma_ind_has_data_i, req_ready_o, cnf_valid_o;
  logic cnf_has_data_o, ma_req_o, ma_seq_o, ma_has_data_o, management_alert_o, e_sq;
  logic [1:0] cnf_prio_o, ma_prio_o, e_k, e_st;
  logic [2:0] ma_type_o, ma_ind_type_i;
  logic seqm [16];
  int err_count = 0, compares = 0, n_req = 0, n_cnf = 0, n_al = 0;
  //////////////////////////////////////////////////////////////////
  // Machine under test and medium partner
  llrm_local #(.OWN_SAP(8'h5A), .OWN_PRIO(2'h3)) dut_u (.sys_clk_i, .srst_i, .local_active_i, .req_valid_i,
    .req_kind_i, .req_dsap_i, .req_ra_i, .req_data_i, .req_ready_o, .valid_ok_i, .valid_fail_i, .valid_status_i,
    .cnf_valid_o, .cnf_kind_o, .cnf_status_o, .cnf_ssap_o, .cnf_dsap_o, .cnf_ra_o, .cnf_prio_o, .cnf_data_o,
    .cnf_has_data_o, .ma_req_o, .ma_da_o, .ma_type_o, .ma_seq_o, .ma_ssap_o, .ma_dsap_o, .ma_data_o,
    .ma_has_data_o, .ma_ctl_o, .ma_prio_o, .ma_cnf_i, .ma_cnf_status_i, .ma_ind_i, .ma_ind_sa_i, .ma_ind_ssap_i,
    .ma_ind_type_i, .ma_ind_data_i, .ma_ind_has_data_i, .management_alert_o);
  llrm_ma_model ma_u (.sys_clk_i, .mode_i(mode), .dly_i(dly), .rsp_data_i(rsp), .ma_req_i(ma_req_o),
    .ma_da_i(ma_da_o), .ma_type_i(ma_type_o), .ma_dsap_i(ma_dsap_o), .ma_ctl_i(ma_ctl_o), .cnf_o(ma_cnf_i),
    .cnf_status_o(ma_cnf_status_i), .ind_o(ma_ind_i), .sa_o(ma_ind_sa_i), .ssap_o(ma_ind_ssap_i),
    .type_o(ma_ind_type_i), .data_o(ma_ind_data_i), .has_data_o(ma_ind_has_data_i));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  //////////////////////////////////////////////////////////////////
  // Helpers: random source, expectations, compare, verdict
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function automatic logic [2:0] exp_type(input logic [1:0] k);
    if (k == 2'h0) return llrm_pkg::LLRM_ACK_DATA_FRAME_TYPE;
    if (k == 2'h1) return llrm_pkg::LLRM_NOACK_DATA_FRAME_TYPE;
    return llrm_pkg::LLRM_REQUEST_DATA_FRAME_TYPE;
  endfunction : exp_type
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (exp !== got) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Check each frame and confirmation where it appears
  always @(negedge sys_clk_i) begin
    if (ma_req_o) begin
      n_req++;
      chk("ma_da", e_ra, ma_da_o);
      chk("ma_type", exp_type(e_k), ma_type_o);
      chk("ma_seq", e_sq, ma_seq_o);
      chk("ma_ctl", (e_k == 2'h1) ? 2'h0 : 2'h1, ma_ctl_o);
      chk("ma_dsap", e_ds, ma_dsap_o);
      chk("ma_ssap", 8'h5A, ma_ssap_o);
      chk("ma_prio", 2'h3, ma_prio_o);
      chk("ma_has", e_k != 2'h2, ma_has_data_o);
      chk("ma_data", (e_k != 2'h2) ? e_dt : 32'h0, ma_data_o);
    end
    if (cnf_valid_o) begin
      n_cnf++;
      chk("cnf_kind", e_k, cnf_kind_o);
      chk("cnf_status", e_st, cnf_status_o);
      chk("cnf_ra", e_ra, cnf_ra_o);
      chk("cnf_dsap", e_ds, cnf_dsap_o);
      chk("cnf_ssap", 8'h5A, cnf_ssap_o);
      chk("cnf_prio", 2'h3, cnf_prio_o);
      chk("cnf_has", e_k == 2'h2 && e_st == 2'h0, cnf_has_data_o);
      chk("cnf_data", (e_k == 2'h2 && e_st == 2'h0) ? rsp : 32'h0, cnf_data_o);
    end
    if (management_alert_o) n_al++;
  end
  // One request; m: 0 ok, 1 medium fail, 2 stray frame, 3 refused
  task automatic op(input logic [1:0] k, input logic [1:0] m, input logic [3:0] ra);
    logic al;
    al = m == 2'h2 && k != 2'h1;
    n_req = 0;
    n_cnf = 0;
    n_al = 0;
    e_k = k;
    e_ra = ra;
    e_ds = rnd();
    e_dt = rnd();
    e_sq = (k == 2'h1) ? llrm_pkg::LLRM_NOACK_SEQ : seqm[ra];
    e_st = (m == 2'h3 || m == 2'h1) ? 2'h2 : 2'h0;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_kind_i <= k;
    req_dsap_i <= e_ds;
    req_ra_i <= ra;
    req_data_i <= e_dt;
    mode <= m;
    dly <= rnd();
    rsp <= rnd();
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    req_data_i <= rnd();
    req_ra_i <= rnd();
    valid_ok_i <= m != 2'h3;
    valid_fail_i <= m == 2'h3;
    valid_status_i <= 2'h2;
    @(posedge sys_clk_i);
    if (rnd() & 32'h1) begin
      valid_ok_i <= 1'b0;
      valid_fail_i <= 1'b0;
    end
    @(posedge sys_clk_i);
    valid_ok_i <= 1'b0;
    valid_fail_i <= 1'b0;
    for (int i = 0; i < 40 && n_cnf + n_al == 0; i++) @(posedge sys_clk_i);
    repeat (3) @(posedge sys_clk_i);
    chk("frames", m != 2'h3, n_req);
    chk("confirms", !al, n_cnf);
    chk("alerts", al, n_al);
    if (k != 2'h1 && m == 2'h0) seqm[ra] = ~seqm[ra];
  endtask : op
  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    foreach (seqm[i]) seqm[i] = llrm_pkg::LLRM_SEQ_RST;
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk("ready_cfg", 1'b0, req_ready_o);
    local_active_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    chk("ready_idle", 1'b1, req_ready_o);
    op(2'h0, 2'h0, 4'hF);
    op(2'h0, 2'h0, 4'hF);
    op(2'h2, 2'h2, 4'hF);
    op(2'h2, 2'h0, 4'hF);
    op(2'h1, 2'h1, 4'h0);
    // Unknown kind and inactive machine take nothing
    n_req = 0;
    n_cnf = 0;
    req_valid_i <= 1'b1;
    req_kind_i <= 2'h3;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    valid_ok_i <= 1'b1;
    @(posedge sys_clk_i);
    valid_ok_i <= 1'b0;
    local_active_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk("ready_off", 1'b0, req_ready_o);
    chk("kind3_silent", 0, n_req + n_cnf);
    local_active_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 60; i++) op(rnd() % 3, rnd(), rnd());
    wrap_up();
  end
  // Watchdog
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule : test_link_local_request_machine
`default_nettype wire
